//--- logic/wdt_cfg_pkg.sv
// Package with addresses, register indexes, keys and timing constants for the watchdog configuration port.
package wdt_cfg_pkg;

    // ************************************************************
    // Host I/O locations and keys
    // ************************************************************
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h002E;
    localparam logic [15:0] DATA_PORT_ADDR  = 16'h002F;
    localparam logic [7:0]  UNLOCK_KEY      = 8'h87;
    localparam logic [7:0]  LOCK_KEY        = 8'hAA;

    // ************************************************************
    // Configuration register indexes
    // ************************************************************
    localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
    localparam logic [7:0] IDX_UNIT_CONTROL  = 8'hF5;
    localparam logic [7:0] IDX_TIMEOUT_COUNT = 8'hF6;
    localparam logic [7:0] WATCHDOG_DEVICE   = 8'h08;
    localparam int         UNIT_MINUTE_BIT   = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] DEVICE_SELECT_RESET = 8'h00;
    localparam logic [7:0] UNIT_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] TIMEOUT_COUNT_RESET = 8'h00;
    localparam logic [7:0] LOCKED_READ_VALUE   = 8'hFF;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLOCK_HZ         = 50_000_000;
    localparam int SECOND_S         = 1;
    localparam int MINUTE_S         = 60;
    localparam int CYCLES_PER_SEC   = CLOCK_HZ * SECOND_S;
    localparam int UNITS_PER_MINUTE = MINUTE_S / SECOND_S;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0]
    {
        LOCKED    = 2'b00,
        KEY_SEEN  = 2'b01,
        UNLOCKED  = 2'b11
    } mode_type;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } io_req_type;

endpackage

//--- logic/wdt_countdown.sv
// Watchdog countdown: prescaler for seconds or minutes and the timeout counter.
`timescale 1ns/1ps
`default_nettype none

module wdt_countdown
#(
    parameter int CYCLES_PER_UNIT = wdt_cfg_pkg::CYCLES_PER_SEC
)
(
    // Clock, reset and enable
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       enable_in,
    // Control
    input  wire logic       load_in,
    input  wire logic [7:0] load_value_in,
    input  wire logic       minutes_in,
    // Status
    output logic [7:0]      count_out,
    output logic            timeout_out
);
    import wdt_cfg_pkg::*;

    logic [31:0] tick_r;
    logic [31:0] tick_nxt;
    logic [5:0]  minute_r;
    logic [5:0]  minute_nxt;
    logic [7:0]  count_nxt;
    logic        timeout_nxt;
    logic        unit_done;

    always_comb
    begin
        tick_nxt    = tick_r;
        minute_nxt  = minute_r;
        count_nxt   = count_out;
        timeout_nxt = 1'b0;
        unit_done   = 1'b0;
        if (load_in)
        begin
            // A new count restarts the unit so the first step is a whole unit.
            tick_nxt   = '0;
            minute_nxt = '0;
            count_nxt  = load_value_in;
        end
        else if (count_out != 8'h00)
        begin
            if (tick_r == 32'(CYCLES_PER_UNIT - 1))
            begin
                tick_nxt = '0;
                if (!minutes_in || minute_r == 6'(UNITS_PER_MINUTE - 1))
                begin
                    minute_nxt = '0;
                    unit_done  = 1'b1;
                end
                else
                begin
                    minute_nxt = minute_r + 6'h01;
                end
            end
            else
            begin
                tick_nxt = tick_r + 32'h1;
            end
            if (unit_done)
            begin
                count_nxt   = count_out - 8'h01;
                timeout_nxt = (count_out == 8'h01);
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            tick_r      <= '0;
            minute_r    <= '0;
            count_out   <= TIMEOUT_COUNT_RESET;
            timeout_out <= 1'b0;
        end
        else if (enable_in)
        begin
            tick_r      <= tick_nxt;
            minute_r    <= minute_nxt;
            count_out   <= count_nxt;
            timeout_out <= timeout_nxt;
        end
    end

    a_timeout_at_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
        $rose(timeout_out) |-> count_out == 8'h00 && $past(count_out) == 8'h01)
        else $error("Timeout pulse without the count reaching zero.");

    a_load_takes_value: assert property (@(posedge clock_in) disable iff (!nrst_in)
        load_in && enable_in |=> count_out == $past(load_value_in))
        else $error("Loaded count not taken.");

endmodule

`default_nettype wire

//--- logic/wdt_config_port.sv
// Configuration index/data port with unlock keys, device select and watchdog registers.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Decode index port at the lower address and data port at the next.
// - Registers are reachable only between unlock and lock.
// - Two successive writes of the unlock key to the index port unlock the mode.
// - Key and index share one location; data sits at index plus one.
// - Index 0x07 with a data write selects the logical device.
// - Later index and data accesses reach the selected device's registers.
// - One lock key write to the index port leaves configuration mode.
// - The watchdog is logical device eight.
// - Bit 3 of register 0xF5 clear selects seconds, set selects minutes.
// - Writing register 0xF6 loads the count and starts countdown at once.
module wdt_config_port
#(
    parameter int CYCLES_PER_UNIT = wdt_cfg_pkg::CYCLES_PER_SEC
)
(
    // Clock, reset and enable
    input  wire logic                     clock_in,
    input  wire logic                     nrst_in,
    input  wire logic                     clock_enable_in,
    // Host I/O request
    input  wire wdt_cfg_pkg::io_req_type  io_req_in,
    // Host read answer
    output logic [7:0]                    read_data_out,
    output logic                          read_valid_out,
    // Status
    output logic                          unlocked_out,
    output logic                          timeout_out
);
    import wdt_cfg_pkg::*;

    // ************************************************************
    // Decode
    // ************************************************************
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic       wdt_sel;
    logic       minutes;
    logic [7:0] wdt_count;
    logic       wdt_load;

    assign index_wr = io_req_in.wr && io_req_in.addr == INDEX_PORT_ADDR;
    assign data_wr  = io_req_in.wr && io_req_in.addr == DATA_PORT_ADDR;
    assign data_rd  = io_req_in.rd && io_req_in.addr == DATA_PORT_ADDR;

    // ************************************************************
    // Mode state machine and register file
    // ************************************************************
    mode_type   mode_r;
    mode_type   mode_nxt;
    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic [7:0] device_r;
    logic [7:0] device_nxt;
    logic [7:0] unit_ctrl_r;
    logic [7:0] unit_ctrl_nxt;
    logic [7:0] rdata_nxt;
    logic       rvalid_nxt;

    assign wdt_sel  = device_r == WATCHDOG_DEVICE;
    assign minutes  = unit_ctrl_r[UNIT_MINUTE_BIT];
    // Only an unlocked data write to the count index of the watchdog reaches the counter.
    assign wdt_load = mode_r == UNLOCKED && data_wr && wdt_sel && index_r == IDX_TIMEOUT_COUNT;

    always_comb
    begin
        mode_nxt      = mode_r;
        index_nxt     = index_r;
        device_nxt    = device_r;
        unit_ctrl_nxt = unit_ctrl_r;
        rdata_nxt     = LOCKED_READ_VALUE;
        rvalid_nxt    = data_rd;
        case (mode_r)
            LOCKED:
            begin
                // Anything but the key is dropped; a data write also breaks the key pair.
                if (index_wr && io_req_in.data == UNLOCK_KEY)
                begin
                    mode_nxt = KEY_SEEN;
                end
            end
            KEY_SEEN:
            begin
                if (index_wr && io_req_in.data == UNLOCK_KEY)
                begin
                    mode_nxt = UNLOCKED;
                end
                else if (io_req_in.wr)
                begin
                    mode_nxt = LOCKED;
                end
            end
            UNLOCKED:
            begin
                if (index_wr)
                begin
                    if (io_req_in.data == LOCK_KEY)
                    begin
                        mode_nxt = LOCKED;
                    end
                    else
                    begin
                        index_nxt = io_req_in.data;
                    end
                end
                else if (data_wr)
                begin
                    if (index_r == IDX_DEVICE_SELECT)
                    begin
                        device_nxt = io_req_in.data;
                    end
                    else if (wdt_sel && index_r == IDX_UNIT_CONTROL)
                    begin
                        unit_ctrl_nxt = io_req_in.data;
                    end
                end
                if (data_rd)
                begin
                    if (index_r == IDX_DEVICE_SELECT)
                    begin
                        rdata_nxt = device_r;
                    end
                    else if (wdt_sel && index_r == IDX_UNIT_CONTROL)
                    begin
                        rdata_nxt = unit_ctrl_r;
                    end
                    else if (wdt_sel && index_r == IDX_TIMEOUT_COUNT)
                    begin
                        rdata_nxt = wdt_count;
                    end
                    else
                    begin
                        rdata_nxt = 8'h00;
                    end
                end
            end
            default:
            begin
                mode_nxt = LOCKED;
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            mode_r         <= LOCKED;
            index_r        <= 8'h00;
            device_r       <= DEVICE_SELECT_RESET;
            unit_ctrl_r    <= UNIT_CONTROL_RESET;
            read_data_out  <= LOCKED_READ_VALUE;
            read_valid_out <= 1'b0;
            unlocked_out   <= 1'b0;
        end
        else if (clock_enable_in)
        begin
            mode_r         <= mode_nxt;
            index_r        <= index_nxt;
            device_r       <= device_nxt;
            unit_ctrl_r    <= unit_ctrl_nxt;
            read_data_out  <= rdata_nxt;
            read_valid_out <= rvalid_nxt;
            unlocked_out   <= mode_nxt == UNLOCKED;
        end
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    wdt_countdown #(
        .CYCLES_PER_UNIT (CYCLES_PER_UNIT)
    ) countdown (
        .clock_in      (clock_in),
        .nrst_in       (nrst_in),
        .enable_in     (clock_enable_in),
        .load_in       (wdt_load),
        .load_value_in (io_req_in.data),
        .minutes_in    (minutes),
        .count_out     (wdt_count),
        .timeout_out   (timeout_out)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    // Key, one idle cycle with no write, then the second key.
    sequence key_pair;
        index_wr && io_req_in.data == UNLOCK_KEY && mode_r == LOCKED && clock_enable_in
        ##1 !io_req_in.wr
        ##1 index_wr && io_req_in.data == UNLOCK_KEY && clock_enable_in;
    endsequence

    a_unlock_by_keys: assert property (@(posedge clock_in) disable iff (!nrst_in)
        key_pair |=> unlocked_out)
        else $error("Two key writes did not unlock.");

    a_lock_by_key: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == UNLOCKED && index_wr && io_req_in.data == LOCK_KEY && clock_enable_in |=> !unlocked_out)
        else $error("Lock key did not lock.");

    a_locked_read_blank: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r != UNLOCKED && data_rd && clock_enable_in |=> read_valid_out && read_data_out == LOCKED_READ_VALUE)
        else $error("Locked read returned contents.");

    a_locked_no_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == LOCKED |=> $stable(device_r) && $stable(unit_ctrl_r))
        else $error("Register changed while locked.");

    a_device_select: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == UNLOCKED && data_wr && index_r == IDX_DEVICE_SELECT && clock_enable_in
        |=> device_r == $past(io_req_in.data))
        else $error("Device select not written.");

    a_index_latch: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == UNLOCKED && index_wr && io_req_in.data != LOCK_KEY && clock_enable_in
        |=> index_r == $past(io_req_in.data))
        else $error("Index not latched.");

    a_broken_key: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == KEY_SEEN && data_wr && clock_enable_in |=> mode_r == LOCKED)
        else $error("Intervening write did not break the key pair.");

    a_unit_write: assert property (@(posedge clock_in) disable iff (!nrst_in)
        mode_r == UNLOCKED && data_wr && index_r == IDX_UNIT_CONTROL && clock_enable_in
        |=> unit_ctrl_r == ($past(wdt_sel) ? $past(io_req_in.data) : $past(unit_ctrl_r)))
        else $error("Unit control write misrouted.");

endmodule

`default_nettype wire

//--- verif/host_io_model.sv
// Host processor model issuing byte writes and reads on the index and data ports.
`timescale 1ns/1ps
`default_nettype none

module host_io_model
(
    // Clock
    input  wire logic                    clock_in,
    // Request toward the port
    output var wdt_cfg_pkg::io_req_type  io_req_out,
    // Answer from the port
    input  wire logic [7:0]              read_data_in,
    input  wire logic                    read_valid_in
);
    import wdt_cfg_pkg::*;

    initial io_req_out = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, data: 8'h00};

    // ************************************************************
    // Single port cycles
    // ************************************************************
    // Released lines show the inverse of the last value so that sampling outside a strobe is caught.
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        io_req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
        @(posedge clock_in);
        io_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
    endtask

    task automatic io_read(input logic [15:0] addr, output logic [7:0] data, output logic valid);
        @(posedge clock_in);
        io_req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h5A};
        @(posedge clock_in);
        io_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: 8'hA5};
        #1;
        data = read_data_in;
        valid = read_valid_in;
    endtask

    // ************************************************************
    // Configuration sequences
    // ************************************************************
    task automatic unlock;
        io_write(INDEX_PORT_ADDR, UNLOCK_KEY);
        io_write(INDEX_PORT_ADDR, UNLOCK_KEY);
    endtask

    task automatic lock;
        io_write(INDEX_PORT_ADDR, LOCK_KEY);
    endtask

    task automatic reg_write(input logic [7:0] idx, input logic [7:0] val);
        io_write(INDEX_PORT_ADDR, idx);
        io_write(DATA_PORT_ADDR, val);
    endtask

    task automatic reg_read(input logic [7:0] idx, output logic [7:0] data, output logic valid);
        io_write(INDEX_PORT_ADDR, idx);
        io_read(DATA_PORT_ADDR, data, valid);
    endtask
endmodule

`default_nettype wire

//--- verif/wdt_config_port_tb.sv
// Self-checking testbench for the configuration port and watchdog registers.
`timescale 1ns/1ps
`default_nettype none

module wdt_config_port_tb;
    import wdt_cfg_pkg::*;

    logic        clock_in;
    logic        nrst_in;
    logic        clock_enable_in;
    io_req_type  io_req;
    logic [7:0]  read_data;
    logic        read_valid;
    logic        unlocked;
    logic        timeout;
    // A short unit keeps the seconds and minutes timeouts within a few thousand cycles.
    localparam int UNIT       = 64;
    localparam int WAIT_LIMIT = 4000;

    logic        seen_timeout = 1'b0;
    logic [7:0]  d;
    logic        v;
    logic [15:0] took;
    int          bad_count;
    int          n_checks;
    int          cyc = 0;

    wdt_config_port
    #(
        .CYCLES_PER_UNIT (UNIT)
    )
    u_dut
    (
        .clock_in        (clock_in),
        .nrst_in         (nrst_in),
        .clock_enable_in (clock_enable_in),
        .io_req_in       (io_req),
        .read_data_out   (read_data),
        .read_valid_out  (read_valid),
        .unlocked_out    (unlocked),
        .timeout_out     (timeout)
    );

    host_io_model u_host
    (
        .clock_in      (clock_in),
        .io_req_out    (io_req),
        .read_data_in  (read_data),
        .read_valid_in (read_valid)
    );

    // ************************************************************
    // Clock, cycle ceiling and report
    // ************************************************************
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The whole sequence needs about 4200 cycles, mostly the minute timeout; the ceiling leaves margin.
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (timeout === 1'b1)
            seen_timeout <= 1'b1;
        if (cyc == 8000)
        begin
            bad_count = bad_count + 1;
            wrap_up();
        end
    end

    // ************************************************************
    // Comparisons
    // ************************************************************
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_cycles(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counts edges after the load edge until the timeout pulse shows, giving up at the limit.
    task automatic wait_timeout(output logic [15:0] n);
        n = 16'h0000;
        do
        begin
            @(posedge clock_in);
            #1;
            n = n + 16'h0001;
        end
        while (timeout !== 1'b1 && n < 16'(WAIT_LIMIT));
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        u_host.reg_read(idx, d, v);
        check_bit(v, 1'b1);
        check_byte(d, exp);
    endtask

    task automatic port_chk(input logic [15:0] addr, input logic [7:0] exp);
        u_host.io_read(addr, d, v);
        check_bit(v, 1'b1);
        check_byte(d, exp);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        nrst_in = 1'b0;
        clock_enable_in = 1'b1;
        bad_count = 0;
        n_checks = 0;
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        #1;
        check_byte(read_data, LOCKED_READ_VALUE);
        check_bit(read_valid, 1'b0);
        check_bit(unlocked, 1'b0);
        // Writes and reads while locked.
        u_host.reg_write(IDX_DEVICE_SELECT, WATCHDOG_DEVICE);
        port_chk(DATA_PORT_ADDR, LOCKED_READ_VALUE);
        // A key written to the data port breaks the pair.
        u_host.io_write(INDEX_PORT_ADDR, UNLOCK_KEY);
        u_host.io_write(DATA_PORT_ADDR, UNLOCK_KEY);
        #1 check_bit(unlocked, 1'b0);
        // A read between the two keys does not break the pair.
        u_host.io_write(INDEX_PORT_ADDR, UNLOCK_KEY);
        port_chk(DATA_PORT_ADDR, LOCKED_READ_VALUE);
        #1 check_bit(unlocked, 1'b0);
        u_host.io_write(INDEX_PORT_ADDR, UNLOCK_KEY);
        #1 check_bit(unlocked, 1'b1);
        rd_chk(IDX_DEVICE_SELECT, DEVICE_SELECT_RESET);
        // Watchdog registers are not reached through another device.
        u_host.reg_write(IDX_DEVICE_SELECT, 8'h03);
        u_host.reg_write(IDX_TIMEOUT_COUNT, 8'h1E);
        u_host.reg_write(IDX_UNIT_CONTROL, 8'h08);
        rd_chk(IDX_DEVICE_SELECT, 8'h03);
        u_host.reg_write(IDX_DEVICE_SELECT, WATCHDOG_DEVICE);
        rd_chk(IDX_DEVICE_SELECT, WATCHDOG_DEVICE);
        rd_chk(IDX_TIMEOUT_COUNT, TIMEOUT_COUNT_RESET);
        rd_chk(IDX_UNIT_CONTROL, UNIT_CONTROL_RESET);
        // Read-modify-write of the unit bit; the index persists across data accesses.
        u_host.reg_write(IDX_UNIT_CONTROL, 8'h08);
        rd_chk(IDX_UNIT_CONTROL, 8'h08);
        port_chk(DATA_PORT_ADDR, 8'h08);
        u_host.io_write(DATA_PORT_ADDR, d & ~8'h08);
        rd_chk(IDX_UNIT_CONTROL, 8'h00);
        // Load the count; it reads back live and no timeout is due yet.
        u_host.reg_write(IDX_TIMEOUT_COUNT, 8'd30);
        rd_chk(IDX_TIMEOUT_COUNT, 8'd30);
        rd_chk(8'h30, 8'h00);
        // A lock key offered while the clock enable is low is not taken.
        @(posedge clock_in);
        clock_enable_in <= 1'b0;
        u_host.io_write(INDEX_PORT_ADDR, LOCK_KEY);
        clock_enable_in <= 1'b1;
        #1 check_bit(unlocked, 1'b1);
        u_host.lock();
        #1 check_bit(unlocked, 1'b0);
        port_chk(DATA_PORT_ADDR, LOCKED_READ_VALUE);
        u_host.reg_write(IDX_DEVICE_SELECT, 8'h05);
        u_host.unlock();
        rd_chk(IDX_DEVICE_SELECT, WATCHDOG_DEVICE);
        rd_chk(IDX_TIMEOUT_COUNT, 8'd30);
        u_host.lock();
        check_bit(seen_timeout, 1'b0);
        // Seconds: a unit and a half in, the count has stepped once; a reload restarts the unit.
        u_host.unlock();
        u_host.reg_write(IDX_TIMEOUT_COUNT, 8'h02);
        repeat (UNIT + UNIT / 2) @(posedge clock_in);
        rd_chk(IDX_TIMEOUT_COUNT, 8'h01);
        u_host.reg_write(IDX_TIMEOUT_COUNT, 8'h02);
        wait_timeout(took);
        check_cycles(took, 16'(2 * UNIT));
        @(posedge clock_in);
        #1 check_bit(timeout, 1'b0);
        rd_chk(IDX_TIMEOUT_COUNT, 8'h00);
        // Minutes: a count of one lasts sixty seconds.
        u_host.reg_write(IDX_UNIT_CONTROL, 8'h08);
        u_host.reg_write(IDX_TIMEOUT_COUNT, 8'h01);
        wait_timeout(took);
        check_cycles(took, 16'(UNITS_PER_MINUTE * UNIT));
        u_host.lock();
        #1 check_bit(unlocked, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
